/* tlsel_top.sv */
`timescale 1ns/100ps
`include "tlsel_consts.svh"

// Functional notes
// - Limiting acts only when the characteristic selects sensorless vector control; activeLimit still follows the selected mode under any characteristic.
// - Quadrant mode uses limits 1 to 4 for fwd power, rev regen, rev power, fwd regen.
// - Terminal mode picks one stored limit from the two select inputs for all quadrants.
// - Analog mode scales input linearly from zero to the top limit for all quadrants.
// - With the gate input assigned, the mode acts only while it is on, else maximum torque.
// - With no gate input assigned, the selected mode is always active.
// - Limits are percent of rated torque, torque at maximum current being the top of scale.
// - The limiting-active output, when assigned, is on while limiting operates.
// - Each quadrant limit holds zero to top of scale or a disabled code, resetting to top.
// - One hundred percent refers to rated current when scaling limits.
module tlsel_top
    import tlsel_pkg::*;
#(
    parameter int ADC_W = 10
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Drive control loop
    input  wire logic [1:0]       vfCharacteristic,
    input  wire logic [1:0]       operatingQuadrant,
    input  wire logic             torqueAtLimit,
    input  wire logic [ADC_W-1:0] analogVoltage,
    // Intelligent input terminals
    input  wire logic             limitSelectBit0,
    input  wire logic             limitSelectBit1,
    input  wire logic             limitGateInput,
    // Outputs
    output logic      [7:0]       activeLimit,
    output logic                  limitEnabled,
    output logic                  limitingActiveOutput,
    output logic                  irq
);
    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [6:0]  ctrl_reg;
    logic [7:0]  limit_reg [4];
    logic [1:0]  irqStat_reg;
    logic [1:0]  irqMask_reg;
    logic [7:0]  activeLimit_reg;
    logic [7:0]  activeLimit_next;
    logic        enabled_reg;
    logic        limiting_reg;
    logic        irq_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [7:0]  analogPct;

    tlsel_analog_scale #(
        .ADC_W    (ADC_W)
    ) u_scale (
        .clk      (clk),
        .rst      (rst),
        .adcCode  (analogVoltage),
        .limitPct (analogPct)
    );

    // -------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------
    wire         setup   = psel && !penable;
    wire         wrEn    = setup && pwrite;
    wire         rdEn    = setup && !pwrite;
    wire         selCtrl = paddr == `TLSEL_OFF_CTRL;
    wire         selL1   = paddr == `TLSEL_OFF_LIM1;
    wire         selL2   = paddr == `TLSEL_OFF_LIM2;
    wire         selL3   = paddr == `TLSEL_OFF_LIM3;
    wire         selL4   = paddr == `TLSEL_OFF_LIM4;
    wire         selSt   = paddr == `TLSEL_OFF_STATUS;
    wire         selIs   = paddr == `TLSEL_OFF_IRQSTAT;
    wire         selIm   = paddr == `TLSEL_OFF_IRQMASK;
    wire         selLim  = paddr == `TLSEL_OFF_LIMIT;
    wire [3:0]   selLimV = {selL4, selL3, selL2, selL1};
    wire         mapped  = selCtrl || (|selLimV) || selSt || selIs || selIm || selLim;
    wire [7:0]   wrByte  = pwdata[7:0];
    wire         byteOk  = wrByte <= `TLSEL_TOP_PCT || wrByte == `TLSEL_DISABLED;

    wire tlsel_mode_t mode = tlsel_mode_t'(ctrl_reg[`TLSEL_CTRL_MODE_HI:`TLSEL_CTRL_MODE_LO]);
    wire         slvSel  = ctrl_reg[`TLSEL_CTRL_SLV];
    wire         gateAsg = ctrl_reg[`TLSEL_CTRL_GATEASG];
    wire         outAsg  = ctrl_reg[`TLSEL_CTRL_OUTASG];
    wire         slvOn   = vfCharacteristic == `TLSEL_VF_SLV && slvSel;
    wire         gateOn  = !gateAsg || limitGateInput;
    wire [1:0]   termIdx = {limitSelectBit1, limitSelectBit0};
    wire [1:0]   quadIdx = operatingQuadrant;

    // Disabled code means no limit, which equals the top of scale
    wire [7:0]   quadLim = limit_reg[quadIdx] == `TLSEL_DISABLED ? `TLSEL_TOP_PCT
                                                                 : limit_reg[quadIdx];
    wire [7:0]   termLim = limit_reg[termIdx] == `TLSEL_DISABLED ? `TLSEL_TOP_PCT
                                                                 : limit_reg[termIdx];
    wire         newOn   = slvOn && torqueAtLimit && outAsg;

    // -------------------------------------------------------------------
    // Limit selection
    // -------------------------------------------------------------------
    always_comb begin
        case (mode)
            TLSEL_QUADRANT: activeLimit_next = quadLim;
            TLSEL_TERMINAL: activeLimit_next = termLim;
            TLSEL_ANALOG:   activeLimit_next = analogPct;
            default:        activeLimit_next = `TLSEL_TOP_PCT;
        endcase
        if (!gateOn) begin
            activeLimit_next = `TLSEL_TOP_PCT;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            activeLimit_reg <= `TLSEL_TOP_PCT;
            enabled_reg     <= 1'b0;
            limiting_reg    <= 1'b0;
        end else begin
            activeLimit_reg <= activeLimit_next;
            enabled_reg     <= slvOn;
            limiting_reg    <= newOn;
        end
    end

    // -------------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lim
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    limit_reg[gi] <= `TLSEL_TOP_PCT;
                end else if (wrEn && selLimV[gi] && byteOk) begin
                    limit_reg[gi] <= wrByte;
                end
            end
        end
    endgenerate

    wire [1:0] irqEvt = {limiting_reg && !newOn, !limiting_reg && newOn};
    wire [1:0] irqClr = (wrEn && selIs) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg    <= 7'h00;
            irqStat_reg <= 2'h0;
            irqMask_reg <= 2'h0;
            irq_reg     <= 1'b0;
        end else begin
            if (wrEn && selCtrl) begin
                ctrl_reg <= pwdata[6:0];
            end
            if (wrEn && selIm) begin
                irqMask_reg <= pwdata[1:0];
            end
            irqStat_reg <= (irqStat_reg & ~irqClr) | irqEvt;
            irq_reg     <= |(irqStat_reg & irqMask_reg);
        end
    end

    wire [31:0] rdMux =
        selCtrl ? {25'h0, ctrl_reg} :
        selL1   ? {24'h0, limit_reg[0]} :
        selL2   ? {24'h0, limit_reg[1]} :
        selL3   ? {24'h0, limit_reg[2]} :
        selL4   ? {24'h0, limit_reg[3]} :
        selSt   ? {29'h0, limiting_reg, enabled_reg, gateOn} :
        selIs   ? {30'h0, irqStat_reg} :
        selIm   ? {30'h0, irqMask_reg} :
        selLim  ? {24'h0, activeLimit_reg} : 32'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !mapped;
            if (rdEn) begin
                prdata_reg <= rdMux;
            end
        end
    end

    assign prdata               = prdata_reg;
    assign pready               = pready_reg;
    assign pslverr              = pslverr_reg;
    assign activeLimit          = activeLimit_reg;
    assign limitEnabled         = enabled_reg;
    assign limitingActiveOutput = limiting_reg;
    assign irq                  = irq_reg;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    property p_quad_sel;
        @(posedge clk) disable iff (rst)
        (mode == TLSEL_QUADRANT && gateOn && limit_reg[quadIdx] != `TLSEL_DISABLED)
            |=> activeLimit == $past(limit_reg[quadIdx]);
    endproperty
    a_quad_sel: assert property (p_quad_sel) else $error("Quadrant limit wrong");

    property p_term_sel;
        @(posedge clk) disable iff (rst)
        (mode == TLSEL_TERMINAL && gateOn && limit_reg[termIdx] != `TLSEL_DISABLED)
            |=> activeLimit == $past(limit_reg[termIdx]);
    endproperty
    a_term_sel: assert property (p_term_sel) else $error("Terminal limit wrong");

    property p_gate_off;
        @(posedge clk) disable iff (rst)
        (gateAsg && !limitGateInput) |=> activeLimit == `TLSEL_TOP_PCT;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("Gate off must give maximum");

    property p_no_gate;
        @(posedge clk) disable iff (rst)
        (!gateAsg && mode == TLSEL_ANALOG) |=> activeLimit == $past(analogPct);
    endproperty
    a_no_gate: assert property (p_no_gate) else $error("Mode must stay active");

    property p_slv_only;
        @(posedge clk) disable iff (rst)
        (vfCharacteristic != `TLSEL_VF_SLV) |=> !limitingActiveOutput && !limitEnabled;
    endproperty
    a_slv_only: assert property (p_slv_only) else $error("Limiting outside vector control");

    property p_slv_on;
        @(posedge clk) disable iff (rst)
        slvOn |=> limitEnabled;
    endproperty
    a_slv_on: assert property (p_slv_on) else $error("Limiting not enabled");

    property p_dis_top;
        @(posedge clk) disable iff (rst)
        (mode == TLSEL_QUADRANT && gateOn && limit_reg[quadIdx] == `TLSEL_DISABLED)
            |=> activeLimit == `TLSEL_TOP_PCT;
    endproperty
    a_dis_top: assert property (p_dis_top) else $error("Disabled limit must give top");

    property p_out_on;
        @(posedge clk) disable iff (rst)
        (slvOn && outAsg && torqueAtLimit) |=> limitingActiveOutput;
    endproperty
    a_out_on: assert property (p_out_on) else $error("Limiting output missing");

    property p_lim_range;
        @(posedge clk) disable iff (rst)
        1'b1 |-> (limit_reg[0] <= `TLSEL_TOP_PCT || limit_reg[0] == `TLSEL_DISABLED);
    endproperty
    a_lim_range: assert property (p_lim_range) else $error("Limit out of range");

    property p_scale_top;
        @(posedge clk) disable iff (rst)
        1'b1 |-> activeLimit <= `TLSEL_TOP_PCT;
    endproperty
    a_scale_top: assert property (p_scale_top) else $error("Limit above top of scale");

    property p_irq_level;
        @(posedge clk) disable iff (rst)
        |(irqStat_reg & irqMask_reg) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised");

    c_quad:  cover property (@(posedge clk) mode == TLSEL_QUADRANT && limitingActiveOutput);
    c_term:  cover property (@(posedge clk) mode == TLSEL_TERMINAL && termIdx == 2'h3);
    c_anlg:  cover property (@(posedge clk) mode == TLSEL_ANALOG && activeLimit != 8'h00);
    c_gated: cover property (@(posedge clk) gateAsg && !limitGateInput);
endmodule

/* tlsel_consts.svh */
`ifndef TLSEL_CONSTS_SVH
`define TLSEL_CONSTS_SVH

// Register byte offsets
`define TLSEL_OFF_CTRL     12'h000
`define TLSEL_OFF_LIM1     12'h004
`define TLSEL_OFF_LIM2     12'h008
`define TLSEL_OFF_LIM3     12'h00c
`define TLSEL_OFF_LIM4     12'h010
`define TLSEL_OFF_STATUS   12'h014
`define TLSEL_OFF_IRQSTAT  12'h018
`define TLSEL_OFF_IRQMASK  12'h01c
`define TLSEL_OFF_LIMIT    12'h020

// Control field positions
`define TLSEL_CTRL_MODE_LO 0
`define TLSEL_CTRL_MODE_HI 1
`define TLSEL_CTRL_SLV     4
`define TLSEL_CTRL_GATEASG 5
`define TLSEL_CTRL_OUTASG  6

// Limit scale, in percent
`define TLSEL_TOP_PCT      8'hc8
`define TLSEL_DISABLED     8'hff
`define TLSEL_RATED_PCT    8'h64

// Voltage-/frequency-characteristic code for sensorless vector control
`define TLSEL_VF_SLV       2'h3

// Interrupt status bits
`define TLSEL_IRQ_ON       0
`define TLSEL_IRQ_OFF      1

`endif

/* tlsel_pkg.sv */
package tlsel_pkg;
    typedef enum logic [1:0] {
        TLSEL_QUADRANT,
        TLSEL_TERMINAL,
        TLSEL_ANALOG,
        TLSEL_RESERVED
    } tlsel_mode_t;

    typedef enum logic [1:0] {
        TLSEL_FWD_POWER,
        TLSEL_REV_REGEN,
        TLSEL_REV_POWER,
        TLSEL_FWD_REGEN
    } tlsel_quad_t;
endpackage

/* tlsel_analog_scale.sv */
`timescale 1ns/100ps
`include "tlsel_consts.svh"

module tlsel_analog_scale
    import tlsel_pkg::*;
#(
    parameter int ADC_W = 10
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Analog sample, 0 to full scale
    input  wire logic [ADC_W-1:0] adcCode,
    // Scaled limit in percent
    output logic      [7:0]       limitPct
);
    localparam int FULL = (1 << ADC_W) - 1;

    wire [ADC_W+7:0] product = adcCode * (ADC_W + 8)'(`TLSEL_TOP_PCT);
    wire [ADC_W+7:0] quot    = product / (ADC_W + 8)'(FULL);

    logic [7:0] limitPct_reg;

    // -------------------------------------------------------------------
    // Linear scaling
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            limitPct_reg <= 8'h00;
        end else begin
            limitPct_reg <= quot[7:0];
        end
    end

    assign limitPct = limitPct_reg;

    property p_zero_gives_zero;
        @(posedge clk) disable iff (rst)
        adcCode == '0 |=> limitPct == 8'h00;
    endproperty
    a_zero_gives_zero: assert property (p_zero_gives_zero)
        else $error("Zero input must give zero limit");

    property p_full_gives_top;
        @(posedge clk) disable iff (rst)
        adcCode == ADC_W'(FULL) |=> limitPct == `TLSEL_TOP_PCT;
    endproperty
    a_full_gives_top: assert property (p_full_gives_top)
        else $error("Full scale must give top limit");
endmodule

/* tlsel_drive_model.sv */
`timescale 1ns/100ps

// ----------------------------------------
// Control loop and input terminal model
// ----------------------------------------
module tlsel_drive_model
    import tlsel_pkg::*;
#(
    parameter int ADC_W = 10
) (
    // Clock
    input  wire logic             clk,
    // Control loop state
    output logic      [1:0]       vfCharacteristic,
    output logic      [1:0]       operatingQuadrant,
    output logic                  torqueAtLimit,
    output logic      [ADC_W-1:0] analogVoltage,
    // Input terminals
    output logic                  limitSelectBit0,
    output logic                  limitSelectBit1,
    output logic                  limitGateInput
);
    initial begin
        vfCharacteristic = 2'h0;
        operatingQuadrant = 2'h0;
        torqueAtLimit = 1'b0;
        analogVoltage = '0;
        limitSelectBit0 = 1'b0;
        limitSelectBit1 = 1'b0;
        limitGateInput = 1'b0;
    end

    // Changes every line just after a rising edge
    task automatic put(input logic [1:0] vf, input logic [1:0] quad, input logic limiting_active_output,
                       input logic [ADC_W-1:0] adc, input logic [1:0] sel, input logic gate);
        @(posedge clk);
        vfCharacteristic <= vf;
        operatingQuadrant <= quad;
        torqueAtLimit <= limiting_active_output;
        analogVoltage <= adc;
        limitSelectBit0 <= sel[0];
        limitSelectBit1 <= sel[1];
        limitGateInput <= gate;
    endtask
endmodule

/* tlsel_top_test.sv */
`timescale 1ns/100ps
`include "tlsel_consts.svh"

module tlsel_top_test
    import tlsel_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [1:0]  vfCharacteristic, operatingQuadrant;
    logic        torqueAtLimit, limitSelectBit0, limitSelectBit1, limitGateInput;
    logic [9:0]  analogVoltage;
    logic [7:0]  activeLimit;
    logic        limitEnabled, limitingActiveOutput, irq;
    logic [7:0]  lim [4] = '{8'h0a, 8'h14, 8'h1e, 8'hff};
    int          failures, total_checks;

    tlsel_top #(.ADC_W(10)) tlsel_top_i (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vfCharacteristic(vfCharacteristic), .operatingQuadrant(operatingQuadrant),
        .torqueAtLimit(torqueAtLimit), .analogVoltage(analogVoltage),
        .limitSelectBit0(limitSelectBit0), .limitSelectBit1(limitSelectBit1),
        .limitGateInput(limitGateInput), .activeLimit(activeLimit),
        .limitEnabled(limitEnabled), .limitingActiveOutput(limitingActiveOutput), .irq(irq));

    tlsel_drive_model #(.ADC_W(10)) tlsel_drive_model_i (.clk(clk),
        .vfCharacteristic(vfCharacteristic), .operatingQuadrant(operatingQuadrant),
        .torqueAtLimit(torqueAtLimit), .analogVoltage(analogVoltage),
        .limitSelectBit0(limitSelectBit0), .limitSelectBit1(limitSelectBit1),
        .limitGateInput(limitGateInput));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_val({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check_val(rdata, exp);
    endtask

    task automatic drive(input logic [1:0] vf, input logic [1:0] quad, input logic limiting_active_output,
                         input logic [9:0] adc, input logic [1:0] sel, input logic gate);
        tlsel_drive_model_i.put(vf, quad, limiting_active_output, adc, sel, gate);
        repeat (4) @(posedge clk);
        #1;
    endtask

    function automatic logic [7:0] eff(input int i);
        return (lim[i] == `TLSEL_DISABLED) ? `TLSEL_TOP_PCT : lim[i];
    endfunction

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        failures = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_val(activeLimit, `TLSEL_TOP_PCT);
        for (int i = 0; i < 4; i++) rd_chk(12'h004 + 12'(4 * i), 32'h0c8);
        rd_chk(`TLSEL_OFF_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) apb(1'b1, 12'h004 + 12'(4 * i), {24'h0, lim[i]});
        apb(1'b1, `TLSEL_OFF_LIM1, 32'h0c9);
        rd_chk(`TLSEL_OFF_LIM1, 32'h00a);
        rd_chk(`TLSEL_OFF_LIM4, 32'h0ff);
        apb(1'b0, 12'h040, 32'h0);
        check_val(rdata, 32'h0);
        check_bit(err, 1'b1);
        apb(1'b1, `TLSEL_OFF_CTRL, 32'h050);
        for (int q = 0; q < 4; q++) begin
            drive(2'h3, 2'(q), 1'b0, 10'h0, 2'(3 - q), 1'b0);
            check_val(activeLimit, eff(q));
        end
        rd_chk(`TLSEL_OFF_LIMIT, 32'h0c8);
        apb(1'b1, `TLSEL_OFF_CTRL, 32'h051);
        for (int s = 0; s < 4; s++) begin
            drive(2'h3, 2'(s ^ 1), 1'b0, 10'h0, 2'(s), 1'b0);
            check_val(activeLimit, eff(s));
        end
        apb(1'b1, `TLSEL_OFF_CTRL, 32'h052);
        drive(2'h3, 2'h1, 1'b0, 10'h000, 2'h0, 1'b0);
        check_val(activeLimit, 8'h00);
        drive(2'h3, 2'h2, 1'b0, 10'h3ff, 2'h0, 1'b0);
        check_val(activeLimit, `TLSEL_TOP_PCT);
        apb(1'b1, `TLSEL_OFF_CTRL, 32'h053);
        drive(2'h3, 2'h0, 1'b0, 10'h0, 2'h0, 1'b0);
        check_val(activeLimit, `TLSEL_TOP_PCT);
        apb(1'b1, `TLSEL_OFF_CTRL, 32'h070);
        drive(2'h3, 2'h0, 1'b0, 10'h0, 2'h0, 1'b0);
        check_val(activeLimit, `TLSEL_TOP_PCT);
        drive(2'h3, 2'h0, 1'b0, 10'h0, 2'h0, 1'b1);
        check_val(activeLimit, eff(0));
        apb(1'b1, `TLSEL_OFF_CTRL, 32'h010);
        drive(2'h3, 2'h0, 1'b1, 10'h0, 2'h0, 1'b0);
        check_bit(limitingActiveOutput, 1'b0);
        apb(1'b1, `TLSEL_OFF_CTRL, 32'h050);
        drive(2'h0, 2'h0, 1'b1, 10'h0, 2'h0, 1'b0);
        check_bit(limitEnabled, 1'b0);
        check_bit(limitingActiveOutput, 1'b0);
        drive(2'h3, 2'h0, 1'b1, 10'h0, 2'h0, 1'b0);
        check_bit(limitEnabled, 1'b1);
        check_bit(limitingActiveOutput, 1'b1);
        apb(1'b1, `TLSEL_OFF_IRQSTAT, 32'h3);
        apb(1'b1, `TLSEL_OFF_IRQMASK, 32'h0);
        drive(2'h3, 2'h0, 1'b0, 10'h0, 2'h0, 1'b0);
        rd_chk(`TLSEL_OFF_IRQSTAT, 32'h2);
        check_bit(irq, 1'b0);
        apb(1'b1, `TLSEL_OFF_IRQMASK, 32'h2);
        drive(2'h3, 2'h0, 1'b0, 10'h0, 2'h0, 1'b0);
        check_bit(irq, 1'b1);
        apb(1'b1, `TLSEL_OFF_IRQSTAT, 32'h2);
        drive(2'h3, 2'h0, 1'b1, 10'h0, 2'h0, 1'b0);
        check_bit(irq, 1'b0);
        rd_chk(`TLSEL_OFF_IRQSTAT, 32'h1);
        apb(1'b1, `TLSEL_OFF_IRQMASK, 32'h3);
        drive(2'h3, 2'h0, 1'b1, 10'h0, 2'h0, 1'b0);
        check_bit(irq, 1'b1);
        summarize();
    end
endmodule
